// ==== design/scl_cfg.svh ====
// constants for the sequencer clock, timer and logic core
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH
// ********************************************************
// clock rates and timer span
// ********************************************************
`define SCL_CORE_HZ 20000000
`define SCL_MCLK_HZ 8000000
`define SCL_PRESCALE 32
`define SCL_TMR_MIN_US 32
`define SCL_TMR_MAX_MS 1960
`define SCL_TMR_STEPS 128
// ********************************************************
// logic array sizes
// ********************************************************
`define SCL_NUM_LIT 83
`define SCL_NUM_MC 48
`define SCL_NUM_OUT 20
`define SCL_NUM_HV 4
`define SCL_NUM_TMR 4
// ********************************************************
// register byte offsets
// ********************************************************
`define SCL_REG_CLK_CFG 12'h000
`define SCL_REG_OUT_SRC 12'h004
`define SCL_REG_OUT_VAL 12'h008
`define SCL_REG_HV_CFG 12'h00c
`define SCL_REG_STATUS 12'h010
`define SCL_REG_PIN_STATE 12'h014
`define SCL_REG_TMR_CFG 12'h018
`define SCL_REG_MC_LO 12'h01c
`define SCL_REG_MC_HI 12'h020
// ********************************************************
// field positions and reset values
// ********************************************************
`define SCL_CFG_OSC_BIT 0
`define SCL_CFG_PIN_BIT 1
`define SCL_CFG_LCO_BIT 2
`define SCL_CLK_CFG_RST 3'h1
`define SCL_PT_RST 16'h00ff
`define SCL_MC_CTRL_RST 7'h00
`define SCL_TMR_CFG_RST 7'h00
`endif

// ==== design/scl_pkg.sv ====
// types for the sequencer clock, timer and logic core
package scl_pkg;
  // clock mode as {clock_pin_switch, internal_osc_switch}
  typedef enum logic [1:0] {
    SCL_CM_OFF = 2'b00,
    SCL_CM_STANDALONE = 2'b01,
    SCL_CM_SLAVE = 2'b10,
    SCL_CM_MASTER = 2'b11
  } scl_clkmode_e;
  // macrocell storage kind
  typedef enum logic [1:0] {
    SCL_MC_COMB = 2'b00,
    SCL_MC_DFF = 2'b01,
    SCL_MC_TFF = 2'b10,
    SCL_MC_RSVD = 2'b11
  } scl_mcmode_e;
endpackage

// ==== design/scl_timer.sv ====
// one programmable timeout timer on the logic clock tick
`timescale 1ns/10ps
`include "scl_cfg.svh"
module scl_timer import scl_pkg::*; #(
  parameter int CNT_W = 19
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic clear_in, // global reset pin, synchronised
  input wire logic tick_in, // logic clock tick
  input wire logic start_in, // run while high
  input wire logic [6:0] code_in, // timeout step
  output logic expired_out
);
  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired;
  } scl_tmr_s;
  scl_tmr_s s;
  scl_tmr_s next_s;
  localparam int MIN_TICKS = `SCL_TMR_MIN_US * (`SCL_MCLK_HZ / `SCL_PRESCALE) / 1000000;
  // step code: low 3 bits mantissa, high 4 bits exponent;
  // (min + m) << e spans 32us..1.966s in 128 steps
  function automatic logic [CNT_W-1:0] tmr_limit(input logic [6:0] c);
    logic [CNT_W-1:0] base;
    base = CNT_W'(MIN_TICKS) + CNT_W'(c[2:0]);
    return base << c[6:3];
  endfunction
  // ********************************************************
  // counting
  // ********************************************************
  always_comb begin
    next_s = s;
    if (clear_in || !start_in) begin
      next_s.cnt = '0;
      next_s.expired = 1'b0;
    end else if (tick_in && !s.expired) begin
      if (s.cnt + CNT_W'(1) >= tmr_limit(code_in)) begin
        next_s.expired = 1'b1;
      end else begin
        next_s.cnt = s.cnt + CNT_W'(1);
      end
    end
  end
  // frozen while the clock enable is low
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else if (clk_en_in) begin
      s <= next_s;
    end
  end
  assign expired_out = s.expired;
  // ********************************************************
  // checks
  // ********************************************************
  tmr_expire_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(s.expired) |-> $past(s.cnt) + CNT_W'(1) >= tmr_limit($past(code_in)))
    else $error("timer expired before its limit");
  tmr_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && clear_in |=> s.cnt == '0 && !s.expired)
    else $error("timer not cleared by reset");
endmodule

// ==== design/scl_top.sv ====
// clock, timer and macrocell core of the supply sequencer with an ahb-lite register slave
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "scl_cfg.svh"
module scl_top import scl_pkg::*; #(
  parameter int NUM_MC = `SCL_NUM_MC,
  parameter int NUM_LIT = `SCL_NUM_LIT
) (
  input wire logic core_clk_in,
  input wire logic rst_in, // power-on reset
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic mclk_pin_in,
  output logic mclk_pin_out,
  output logic mclk_pin_oe_out,
  output logic logic_clock_out_pin_out,
  input wire logic global_reset_n_in,
  input wire logic [5:0] digital_in,
  input wire logic [23:0] voltage_monitor_input_in,
  input wire logic analog_ready_in,
  output logic [19:0] out_drive_low_out,
  output logic [3:0] gate_drive_outputs_src_out,
  output logic [3:0] gate_drive_outputs_sink_out,
  output logic [7:0] gate_drive_level_out,
  output logic loop_trim_enable_out,
  output logic [1:0] logic_profile_select_out
);
  // ********************************************************
  // derived constants
  // ********************************************************
  localparam int OSC_STEP = `SCL_MCLK_HZ / 1000000; // phase added per core cycle
  localparam int OSC_MOD = `SCL_CORE_HZ / 1000000; // phase wrap
  localparam int PRE_W = $clog2(`SCL_PRESCALE);
  localparam int TSTART = 2 * 16 + 4; // third group cell of timer 0
  localparam int TRIM_MC = TSTART + `SCL_NUM_TMR;
  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [1:0] mpin_s; // clock pin synchroniser
    logic mpin_prev; // edge detect on second stage
    logic [1:0] grst_s; // global reset pin synchroniser
    logic [1:0] ardy_s;
    logic [1:0][5:0] din_s;
    logic [1:0][23:0] voltage_monitor_input_s;
    logic [5:0] din_q; // inputs held on master clock
    logic [23:0] voltage_monitor_input_q; // monitors held on logic clock
    logic [4:0] osc_acc; // oscillator phase
    logic [PRE_W-1:0] presc;
    logic por; // high from power-on until first logic tick
    logic [2:0] clk_cfg;
    logic [19:0] out_src; // 1 = bus owns the pin
    logic [19:0] out_val;
    logic [3:0] hv_gate; // 1 = gate driver
    logic [7:0] hv_lvl;
    logic [3:0][6:0] tmr_cfg;
    logic [NUM_MC-1:0][4:0][15:0] mc_pt;
    logic [NUM_MC-1:0][6:0] mc_ctrl;
    logic [NUM_MC-1:0] mc;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    logic mpin_out;
    logic mpin_oe;
    logic lclk_pin;
    logic [19:0] drive_low;
    logic [3:0] gsrc;
    logic [3:0] gsink;
    logic [7:0] glvl;
    logic trim_en;
    logic [1:0] prof;
  } scl_top_s;
  scl_top_s s;
  scl_top_s next_s;
  // ********************************************************
  // combinational helpers
  // ********************************************************
  logic [NUM_LIT-1:0] lit; // AND-array inputs
  logic [3:0] tmr_exp;
  logic [19:0] pin_val; // logic value per output before the pin stage
  logic osc_tick;
  logic mclk_tick;
  logic ltick;
  logic glob;
  scl_clkmode_e cmode;
  // index past the array reads as constant one
  function automatic logic lit_pick(input logic [NUM_LIT-1:0] v, input logic [6:0] idx);
    return (idx < 7'(NUM_LIT)) ? v[idx] : 1'b1;
  endfunction
  // product term: two literals, each with its own inversion
  function automatic logic pt_eval(input logic [NUM_LIT-1:0] v, input logic [15:0] c);
    return (lit_pick(v, c[6:0]) ^ c[7]) & (lit_pick(v, c[14:8]) ^ c[15]);
  endfunction
  // reset or preset source: none, term four, global pin, power-on
  function automatic logic src_hit(input logic [1:0] sel, input logic pt4, input logic g, input logic p);
    return (sel == 2'd1 && pt4) || (sel == 2'd2 && g) || (sel == 2'd3 && p);
  endfunction
  // ********************************************************
  // clocking
  // ********************************************************
  always_comb begin
    cmode = scl_clkmode_e'({s.clk_cfg[`SCL_CFG_PIN_BIT], s.clk_cfg[`SCL_CFG_OSC_BIT]});
    glob = !s.grst_s[1];
    // oscillator stops whenever the internal switch is open
    osc_tick = s.clk_cfg[`SCL_CFG_OSC_BIT] && (5'(s.osc_acc + 5'(OSC_STEP)) >= 5'(OSC_MOD));
    unique case (cmode)
      SCL_CM_STANDALONE, SCL_CM_MASTER: mclk_tick = osc_tick;
      SCL_CM_SLAVE: mclk_tick = s.mpin_s[1] && !s.mpin_prev;
      SCL_CM_OFF: mclk_tick = 1'b0; // no source: everything on the logic clock halts
    endcase
    ltick = mclk_tick && (s.presc == PRE_W'(`SCL_PRESCALE - 1));
    lit = {tmr_exp, s.ardy_s[1], s.mc, s.voltage_monitor_input_q, s.din_q};
  end
  // per-pin source select: logic group cells or the bus latch
  always_comb begin
    pin_val[7:0] = s.mc[7:0];
    pin_val[15:8] = s.mc[23:16];
    pin_val[19:16] = s.mc[35:32];
    pin_val = (s.out_src & s.out_val) | (~s.out_src & pin_val);
  end
  // ********************************************************
  // timers, started by third group cells
  // ********************************************************
  for (genvar t = 0; t < `SCL_NUM_TMR; t++) begin : g_tmr
    scl_timer u_tmr (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .clk_en_in(clk_en_in),
      .clear_in(glob),
      .tick_in(ltick),
      .start_in(s.mc[TSTART + t]),
      .code_in(s.tmr_cfg[t]),
      .expired_out(tmr_exp[t])
    );
  end
  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    logic [4:0] pt;
    logic orv;
    logic dv;
    logic [5:0] mci;
    logic [11:0] a;
    pt = '0;
    orv = 1'b0;
    dv = 1'b0;
    mci = '0;
    a = '0;
    next_s = s;
    // synchronisers: first stage feeds only the second
    next_s.mpin_s = {s.mpin_s[0], mclk_pin_in};
    next_s.mpin_prev = s.mpin_s[1];
    next_s.grst_s = {s.grst_s[0], global_reset_n_in};
    next_s.ardy_s = {s.ardy_s[0], analog_ready_in};
    next_s.din_s = {s.din_s[0], digital_in};
    next_s.voltage_monitor_input_s = {s.voltage_monitor_input_s[0], voltage_monitor_input_in};
    // oscillator phase, 8 ticks per 20 core cycles
    if (s.clk_cfg[`SCL_CFG_OSC_BIT]) begin
      next_s.osc_acc = osc_tick ? 5'(s.osc_acc + 5'(OSC_STEP) - 5'(OSC_MOD)) : 5'(s.osc_acc + 5'(OSC_STEP));
    end
    if (mclk_tick) begin
      next_s.din_q = s.din_s[1];
      next_s.presc = PRE_W'(s.presc + PRE_W'(1));
    end
    if (ltick) begin
      next_s.voltage_monitor_input_q = s.voltage_monitor_input_s[1];
      next_s.por = 1'b0;
    end
    if (glob) begin
      next_s.presc = '0;
    end
    // macrocells
    for (int i = 0; i < NUM_MC; i++) begin
      for (int k = 0; k < 5; k++) begin
        pt[k] = pt_eval(lit, s.mc_pt[i][k]);
      end
      // xor mode steals term zero from the OR into the XOR stage
      orv = |pt[4:1] | (pt[0] & !s.mc_ctrl[i][3]);
      dv = orv ^ (pt[0] & s.mc_ctrl[i][3]) ^ s.mc_ctrl[i][2];
      unique case (scl_mcmode_e'(s.mc_ctrl[i][1:0]))
        SCL_MC_COMB: next_s.mc[i] = dv;
        SCL_MC_DFF: next_s.mc[i] = ltick ? dv : s.mc[i];
        SCL_MC_TFF: next_s.mc[i] = ltick ? s.mc[i] ^ dv : s.mc[i];
        default: next_s.mc[i] = s.mc[i]; // reserved code holds
      endcase
      // reset beats preset; both act off the logic clock
      if (src_hit(s.mc_ctrl[i][5:4], pt[4], glob, s.por)) begin
        next_s.mc[i] = 1'b0;
      end else if (src_hit({s.mc_ctrl[i][6], 1'b1}, pt[4], glob, s.por)) begin
        next_s.mc[i] = 1'b1;
      end
    end
    // bus data phase: write applied here
    if (s.wr_pend) begin
      a = s.wr_addr;
      mci = 6'(a[9:4] - 6'h10);
      unique case (a)
        `SCL_REG_CLK_CFG: next_s.clk_cfg = hwdata_in[2:0];
        `SCL_REG_OUT_SRC: next_s.out_src = hwdata_in[19:0];
        `SCL_REG_OUT_VAL: next_s.out_val = hwdata_in[19:0];
        `SCL_REG_HV_CFG: begin
          next_s.hv_gate = hwdata_in[3:0];
          next_s.hv_lvl = hwdata_in[11:4];
        end
        `SCL_REG_TMR_CFG: begin
          for (int t = 0; t < 4; t++) begin
            next_s.tmr_cfg[t] = hwdata_in[8*t +: 7];
          end
        end
        default: begin
          if (a[11:10] == 2'b00 && a[9:8] != 2'b00 && mci < 6'(NUM_MC)) begin
            unique case (a[3:2])
              2'd0: next_s.mc_pt[mci][1:0] = hwdata_in;
              2'd1: next_s.mc_pt[mci][3:2] = hwdata_in;
              2'd2: begin
                next_s.mc_pt[mci][4] = hwdata_in[15:0];
                next_s.mc_ctrl[mci] = hwdata_in[22:16];
              end
              default: ; // hole in the cell block
            endcase
          end
        end
      endcase
    end
    // bus address phase; read data taken after the write above
    next_s.wr_pend = 1'b0;
    if (hsel_in && htrans_in[1] && hready_in) begin
      a = haddr_in[11:0];
      mci = 6'(a[9:4] - 6'h10);
      next_s.wr_pend = hwrite_in;
      next_s.wr_addr = {a[11:2], 2'b00};
      next_s.rdata = '0;
      if (!hwrite_in) begin
        unique case ({a[11:2], 2'b00})
          `SCL_REG_CLK_CFG: next_s.rdata = {29'h0, next_s.clk_cfg};
          `SCL_REG_OUT_SRC: next_s.rdata = {12'h0, next_s.out_src};
          `SCL_REG_OUT_VAL: next_s.rdata = {12'h0, next_s.out_val};
          `SCL_REG_HV_CFG: next_s.rdata = {20'h0, next_s.hv_lvl, next_s.hv_gate};
          `SCL_REG_STATUS: next_s.rdata = {19'h0, s.ardy_s[1], tmr_exp, s.presc, cmode == SCL_CM_OFF, cmode};
          `SCL_REG_PIN_STATE: next_s.rdata = {12'h0, pin_val};
          `SCL_REG_TMR_CFG: next_s.rdata = {1'b0, next_s.tmr_cfg[3], 1'b0, next_s.tmr_cfg[2],
                                            1'b0, next_s.tmr_cfg[1], 1'b0, next_s.tmr_cfg[0]};
          `SCL_REG_MC_LO: next_s.rdata = s.mc[31:0];
          `SCL_REG_MC_HI: next_s.rdata = {16'h0, s.mc[47:32]};
          default: begin
            if (a[11:10] == 2'b00 && a[9:8] != 2'b00 && mci < 6'(NUM_MC)) begin
              unique case (a[3:2])
                2'd0: next_s.rdata = next_s.mc_pt[mci][1:0];
                2'd1: next_s.rdata = next_s.mc_pt[mci][3:2];
                2'd2: next_s.rdata = {9'h0, next_s.mc_ctrl[mci], next_s.mc_pt[mci][4]};
                default: next_s.rdata = '0;
              endcase
            end
          end
        endcase
      end
    end
    // clock pin: driven only in master mode, a pulse per oscillator tick
    next_s.mpin_oe = (cmode == SCL_CM_MASTER);
    next_s.mpin_out = (cmode == SCL_CM_MASTER) && osc_tick;
    next_s.lclk_pin = s.clk_cfg[`SCL_CFG_LCO_BIT] && s.presc[PRE_W-1];
    // pin stage: general outputs always open drain
    next_s.drive_low[19:4] = ~pin_val[19:4];
    next_s.drive_low[3:0] = ~pin_val[3:0] & ~s.hv_gate;
    next_s.gsrc = pin_val[3:0] & s.hv_gate;
    next_s.gsink = ~pin_val[3:0] & s.hv_gate;
    next_s.glvl = s.hv_lvl;
    next_s.trim_en = s.mc[TRIM_MC];
    next_s.prof = s.mc[TRIM_MC+2 -: 2];
  end
  // ********************************************************
  // state register, frozen while the clock enable is low
  // ********************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.grst_s <= 2'b11;
      s.por <= 1'b1;
      s.clk_cfg <= `SCL_CLK_CFG_RST;
      s.mc_pt <= {(NUM_MC * 5){`SCL_PT_RST}};
      s.mc_ctrl <= {NUM_MC{`SCL_MC_CTRL_RST}};
      s.tmr_cfg <= {4{`SCL_TMR_CFG_RST}};
      s.drive_low <= '1;
    end else if (clk_en_in) begin
      s <= next_s;
    end
  end
  // ********************************************************
  // outputs, all from flops except the tied-off hreadyout_out and hresp_out
  // ********************************************************
  assign hrdata_out = s.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign mclk_pin_out = s.mpin_out;
  assign mclk_pin_oe_out = s.mpin_oe;
  assign logic_clock_out_pin_out = s.lclk_pin;
  assign out_drive_low_out = s.drive_low;
  assign gate_drive_outputs_src_out = s.gsrc;
  assign gate_drive_outputs_sink_out = s.gsink;
  assign gate_drive_level_out = s.glvl;
  assign loop_trim_enable_out = s.trim_en;
  assign logic_profile_select_out = s.prof;
  // ********************************************************
  // checks
  // ********************************************************
  presc_wrap_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && ltick && !glob |=> s.presc == '0)
    else $error("prescaler did not wrap at 32");
  master_pin_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && cmode == SCL_CM_MASTER && osc_tick |=> mclk_pin_out && mclk_pin_oe_out)
    else $error("master clock not driven out");
  standalone_hiz_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && cmode != SCL_CM_MASTER |=> !mclk_pin_oe_out)
    else $error("clock pin driven outside master mode");
  slave_src_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && cmode == SCL_CM_SLAVE && !glob && !(s.mpin_s[1] && !s.mpin_prev) |=> $stable(s.presc))
    else $error("slave not clocked from pin");
  lclk_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !s.clk_cfg[`SCL_CFG_LCO_BIT] |=> !logic_clock_out_pin_out)
    else $error("logic clock on pin while switch open");
  bus_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s.out_src[19] && !s.wr_pend ##1 s.out_src[19] |=> out_drive_low_out[19] == $past(out_drive_low_out[19]))
    else $error("bus-owned pin changed without a write");
  presc_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && glob |=> s.presc == '0)
    else $error("prescaler not cleared by global reset");
  dff_tick_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && s.mc_ctrl[0] == 7'h01 && !ltick |=> $stable(s.mc[0]))
    else $error("d cell changed off the logic clock");
  mc_reset_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && s.mc_ctrl[1][5:4] == 2'd2 && glob |=> !s.mc[1])
    else $error("cell not reset by global reset");
  master_cov: cover property (@(posedge core_clk_in) cmode == SCL_CM_MASTER && mclk_pin_out);
  slave_cov: cover property (@(posedge core_clk_in) cmode == SCL_CM_SLAVE && ltick);
  timer_cov: cover property (@(posedge core_clk_in) $rose(tmr_exp[0]));
  bus_pin_cov: cover property (@(posedge core_clk_in) s.out_src[0] && s.wr_pend);
endmodule

// ==== dv/scl_clk_partner.sv ====
// partner sequencer that owns the shared clock pin as board clock master
`timescale 1ns/10ps
module scl_clk_partner #(
  parameter int HALF = 2
) (
  input wire logic core_clk_in,
  input wire logic en_in,
  output logic pin_out,
  output logic pin_oe_out
);
  int cnt = 0; // core cycles in this half period
  initial begin
    pin_out = 1'b0;
    pin_oe_out = 1'b0;
  end
  // drives only while enabled, so two masters never fight the line
  always @(posedge core_clk_in) begin
    pin_oe_out <= en_in;
    if (!en_in) begin
      cnt <= 0;
      pin_out <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin_out <= ~pin_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== dv/sequencer_clock_timer_logic_bench.sv ====
// self-checking bench for the sequencer clock, timer and logic core
`timescale 1ns/10ps
module sequencer_clock_timer_logic_bench;
  // ********************************************************
  // stimulus, wires and shared tasks
  // ********************************************************
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, grst_n = 1'b1;
  logic pen = 1'b0, idle_pat = 1'b0, lprev = 1'b0;
  logic cen = 1'b1, ardy = 1'b0, b1 = 1'b0;
  logic [5:0] din = 6'h0;
  logic [23:0] voltage_monitor_input = 24'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, prof;
  logic hready, hresp, mout, moe, lclk, trim, pout, poe, mpin;
  logic [19:0] odl;
  logic [3:0] gsrc, gsink;
  logic [7:0] glvl;
  int error_cnt = 0, n_tests = 0, mcnt = 0, lcnt = 0, m0, l0;
  always #25 clk = ~clk;
  // undriven line shows a changing pattern, never a stale level
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign mpin = moe ? mout : (poe ? pout : idle_pat);
  // running tallies of master pulses and logic clock rises
  always @(posedge clk) begin
    mcnt <= mcnt + int'(mout === 1'b1);
    lprev <= lclk;
    if (lclk === 1'b1 && lprev === 1'b0) lcnt <= lcnt + 1;
  end
  scl_top dut_u (.core_clk_in(clk), .rst_in(rst), .clk_en_in(cen), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .mclk_pin_in(mpin),
    .mclk_pin_out(mout), .mclk_pin_oe_out(moe), .logic_clock_out_pin_out(lclk),
    .global_reset_n_in(grst_n), .digital_in(din), .voltage_monitor_input_in(voltage_monitor_input),
    .analog_ready_in(ardy), .out_drive_low_out(odl), .gate_drive_outputs_src_out(gsrc),
    .gate_drive_outputs_sink_out(gsink), .gate_drive_level_out(glvl),
    .loop_trim_enable_out(trim), .logic_profile_select_out(prof));
  scl_clk_partner part_u (.core_clk_in(clk), .en_in(pen), .pin_out(pout), .pin_oe_out(poe));
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one single word transfer: hold address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset();
    bus(12'h000, 1'b0, 32'h0);
    chk(rd, 32'h1, 32'h1);
    chk({31'h0, moe}, 32'h0, 32'h0);
    chk({31'h0, hresp}, 32'h0, 32'h0);
    bus(12'hffc, 1'b0, 32'h0);
    chk(rd, 32'h0, 32'h0);
  endtask
  task automatic t_master();
    bus(12'h000, 1'b1, 32'h7);
    cycles(4);
    chk({31'h0, moe}, 32'h1, 32'h1);
    m0 = mcnt;
    l0 = lcnt;
    cycles(400);
    chk(mcnt - m0, 32'd159, 32'd161);
    chk(lcnt - l0, 32'd4, 32'd6);
    // clock enable low: the logic clock pin must stop
    cen <= 1'b0;
    cycles(2);
    l0 = lcnt;
    cycles(200);
    chk(lcnt - l0, 32'h0, 32'h0);
    cen <= 1'b1;
    bus(12'h000, 1'b1, 32'h3);
    cycles(4);
    l0 = lcnt;
    cycles(200);
    chk(lcnt - l0, 32'h0, 32'h0);
  endtask
  // far side runs the line with a 4 cycle period
  task automatic t_slave();
    bus(12'h000, 1'b1, 32'h6);
    pen <= 1'b1;
    cycles(8);
    chk({31'h0, moe}, 32'h0, 32'h0);
    l0 = lcnt;
    cycles(1280);
    chk(lcnt - l0, 32'd9, 32'd11);
    pen <= 1'b0;
  endtask
  task automatic t_outputs();
    bus(12'h004, 1'b1, 32'hfffff);
    bus(12'h008, 1'b1, 32'h5a5a5);
    cycles(300);
    chk({12'h0, odl}, 32'ha5a5a, 32'ha5a5a);
    bus(12'h00c, 1'b1, 32'he4f);
    cycles(3);
    chk({12'h0, odl}, 32'ha5a50, 32'ha5a50);
    chk({24'h0, gsink, gsrc}, 32'ha5, 32'ha5);
    chk({24'h0, glvl}, 32'he4, 32'he4);
  endtask
  // cells 36, 40, 41 made constant one; code 0 gives 8 logic ticks
  task automatic t_timer();
    bus(12'h000, 1'b1, 32'h3);
    bus(12'h340, 1'b1, 32'h00ff7f7f);
    bus(12'h380, 1'b1, 32'h00ff7f7f);
    bus(12'h390, 1'b1, 32'h00ff7f7f);
    cycles(300);
    chk({29'h0, trim, prof}, 32'h5, 32'h5);
    bus(12'h010, 1'b0, 32'h0);
    chk({31'h0, rd[8]}, 32'h0, 32'h0);
    cycles(500);
    bus(12'h010, 1'b0, 32'h0);
    chk({31'h0, rd[8]}, 32'h1, 32'h1);
    chk({31'h0, rd[12]}, 32'h1, 32'h1);
    grst_n <= 1'b0;
    cycles(6);
    bus(12'h010, 1'b0, 32'h0);
    chk({26'h0, rd[8:3]}, 32'h0, 32'h0);
    grst_n <= 1'b1;
  endtask
  // cell 0 d, cell 1 t with global reset, cell 2 xor stage, cell 3 input and monitor
  task automatic t_cells();
    bus(12'h000, 1'b1, 32'h3);
    din <= 6'h1;
    voltage_monitor_input <= 24'h1;
    ardy <= 1'b1;
    bus(12'h100, 1'b1, 32'h00ff7f7f);
    bus(12'h108, 1'b1, 32'h000100ff);
    bus(12'h110, 1'b1, 32'h00ff7f7f);
    bus(12'h118, 1'b1, 32'h002200ff);
    bus(12'h120, 1'b1, 32'h7f7f7f7f);
    bus(12'h128, 1'b1, 32'h000800ff);
    bus(12'h130, 1'b1, 32'h00ff0600);
    cycles(100);
    bus(12'h01c, 1'b0, 32'h0);
    chk({29'h0, rd[3], rd[2], rd[0]}, 32'h5, 32'h5);
    b1 = rd[1];
    // next read samples exactly one logic tick later in master mode
    cycles(77);
    bus(12'h01c, 1'b0, 32'h0);
    chk({31'h0, rd[1]}, {31'h0, ~b1}, {31'h0, ~b1});
    grst_n <= 1'b0;
    cycles(6);
    bus(12'h01c, 1'b0, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h9, 32'h9);
    grst_n <= 1'b1;
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog well beyond the roughly 3500 cycles of work
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
  initial begin
    cycles(4);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_slave();
    t_outputs();
    t_cells();
    t_timer();
    finish_test();
  end
endmodule
